//--- tpg_regs.svh
// Register offsets, field positions, reset values and word width of the test-pattern generator.
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address of a register is four times its index.
// ----------------------------------------------------------------------
`define TPG_IDX_CUST1_LO  8'h33
`define TPG_IDX_CUST1_HI  8'h34
`define TPG_IDX_CUST2_LO  8'h35
`define TPG_IDX_CUST2_HI  8'h36
`define TPG_IDX_CHAN_SEL  8'h37
`define TPG_IDX_STRM_SEL  8'h38
`define TPG_IDX_COMMON    8'h39
`define TPG_IDX_PAT_RST   8'h3A
`define TPG_IDX_STATUS    8'h3B

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define TPG_Q_SEL_MSB     7
`define TPG_Q_SEL_LSB     4
`define TPG_I_SEL_MSB     3
`define TPG_I_SEL_LSB     0
`define TPG_COMMON_BIT    0
`define TPG_RST_EN_BIT    0
`define TPG_RST_REQ_BIT   1
`define TPG_RESET_BYTE    8'h00
`define TPG_RESET_SEL     4'h0
`define TPG_WORD_W        16

`endif

//--- tpg_pkg.sv
// Types shared by the test-pattern generator modules.
`include "tpg_regs.svh"

package tpg_pkg;

   // Pattern select codes; codes 5 and 10 to 15 are not defined.
   typedef enum logic [3:0] {
      TPG_SEL_NORMAL = 4'h0,
      TPG_SEL_ZEROS  = 4'h1,
      TPG_SEL_ONES   = 4'h2,
      TPG_SEL_TOGGLE = 4'h3,
      TPG_SEL_RAMP   = 4'h4,
      TPG_SEL_SINGLE = 4'h6,
      TPG_SEL_DOUBLE = 4'h7,
      TPG_SEL_DESKEW = 4'h8,
      TPG_SEL_SYNC   = 4'h9
   } tpg_sel_t;

   // One complex sample of the second down-converter.
   typedef struct packed {
      logic [`TPG_WORD_W-1:0] i;
      logic [`TPG_WORD_W-1:0] q;
   } tpg_iq_t;

endpackage

//--- tpg_phase.sv
// Shared ramp counter and alternation phase of the test-pattern generator.
`timescale 1ns/1ps
`default_nettype none

module tpg_phase #(
   parameter int W = 16
) (
   input  wire logic         clock_in,
   input  wire logic         resetn_in,
   input  wire logic         clear_in,
   output logic [W-1:0]      ramp_out,
   output logic              phase_out
);
   import tpg_pkg::*;

   initial begin
      if (W < 2) $error("tpg_phase: W must be at least 2");
   end

   // Ramp wraps from the top code back to zero on its own.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ramp_out <= '0;
      end else if (clear_in) begin
         ramp_out <= '0;
      end else begin
         ramp_out <= ramp_out + W'(1);
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_out <= 1'b0;
      end else if (clear_in) begin
         phase_out <= 1'b0;
      end else begin
         phase_out <= ~phase_out;
      end
   end

   ramp_step_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (resetn_in && !clear_in) |=> ramp_out == W'($past(ramp_out) + W'(1)))
      else $error("ramp did not advance by one");

   pat_clear_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      clear_in |=> (ramp_out == '0) && !phase_out)
      else $error("pattern state not cleared");

endmodule

`default_nettype wire

//--- tpg_stream.sv
// Pattern selector for one output stream, with a registered output word.
`timescale 1ns/1ps
`default_nettype none

module tpg_stream #(
   parameter int W = 16
) (
   input  wire logic         clock_in,
   input  wire logic         resetn_in,
   input  wire logic [3:0]   sel_in,
   input  wire logic [W-1:0] data_in,
   input  wire logic [W-1:0] ramp_in,
   input  wire logic         phase_in,
   input  wire logic [W-1:0] cust1_in,
   input  wire logic [W-1:0] cust2_in,
   output logic [W-1:0]      word_out
);
   import tpg_pkg::*;

   localparam logic [W-1:0] ALT_WORD = {(W/2){2'b10}};

   initial begin
      if (W < 2 || W % 2 != 0) $error("tpg_stream: W must be even and at least 2");
   end

   logic [W-1:0] word_d;

   always_comb begin
      unique case (tpg_sel_t'(sel_in))
         TPG_SEL_NORMAL: word_d = data_in;
         TPG_SEL_ZEROS:  word_d = '0;
         TPG_SEL_ONES:   word_d = '1;
         TPG_SEL_TOGGLE: word_d = phase_in ? ~ALT_WORD : ALT_WORD;
         TPG_SEL_RAMP:   word_d = ramp_in;
         TPG_SEL_SINGLE: word_d = cust1_in;
         TPG_SEL_DOUBLE: word_d = phase_in ? cust2_in : cust1_in;
         TPG_SEL_DESKEW: word_d = ALT_WORD;
         TPG_SEL_SYNC:   word_d = '1;
         default:        word_d = data_in;
      endcase
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         word_out <= '0;
      end else begin
         word_out <= word_d;
      end
   end

   zero_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      sel_in == 4'h1 |=> word_out == '0)
      else $error("all-zeros pattern wrong");

   deskew_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      sel_in == 4'h8 |=> word_out == ALT_WORD)
      else $error("deskew word wrong");

   sync_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      sel_in == 4'h9 |=> word_out == '1)
      else $error("sync word wrong");

   single_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      sel_in == 4'h6 |=> word_out == $past(cust1_in))
      else $error("single custom word wrong");

   double_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (sel_in == 4'h7 && phase_in) |=> word_out == $past(cust2_in))
      else $error("double custom word wrong");

   undef_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (sel_in == 4'h5 || sel_in > 4'h9) |=> word_out == $past(data_in))
      else $error("undefined code did not pass data");

endmodule

`default_nettype wire

//--- tpg_top.sv
// Test-pattern generator for the second down-converter streams, with an APB register slave.
//
// Summary of operation
// - Upper nibble of stream select register picks the Q stream pattern.
// - Lower nibble picks the I stream pattern with the same code table.
// - Code zero passes converter sample data through unaltered.
// - Code one drives all zeros; code two drives all ones.
// - Code three alternates 1010 word and its complement each sample.
// - Code four outputs a ramp stepping by one per clock, wrapping at top.
// - Code six outputs custom word one continuously.
// - Code seven alternates custom word one and custom word two.
// - Code eight outputs the constant deskew word AAAA.
// - Code nine outputs the all-ones sync word FFFF.
// - Common bit clear: all streams follow the channel-wide select.
// - Common bit set: each stream follows its own select nibble.
// - Reset enable bit gates the pattern reset request.
// - Enable then pulse request; while high, ramp and phase return to start.
// - Two custom words in four byte registers, reset to zero.
// - Channel-wide four-bit select uses the same code table.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_regs.svh"

module tpg_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic               clock_in,
   input  wire logic               resetn_in,
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [ADDR_W-1:0]  paddr_in,
   input  wire logic [31:0]        pwdata_in,
   output logic [31:0]             prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   input  wire tpg_pkg::tpg_iq_t   adc_in,
   output tpg_pkg::tpg_iq_t        tp_out
);
   import tpg_pkg::*;

   localparam int W = `TPG_WORD_W;

   initial begin
      if (ADDR_W < 10) $error("tpg_top: ADDR_W must reach index 8'h3B");
   end

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [W-1:0] cust1_q;
   logic [W-1:0] cust2_q;
   logic [3:0]   chan_sel_q;
   logic [7:0]   strm_sel_q;
   logic         common_q;
   logic         rst_en_q;
   logic         rst_req_q;

   logic [ADDR_W-3:0] idx;
   logic              mapped;
   logic              access;
   logic              wr_take;
   logic [31:0]       rd_d;
   logic              pat_clear;
   logic [W-1:0]      ramp_w;
   logic              phase_w;
   logic [3:0]        eff_i_sel;
   logic [3:0]        eff_q_sel;
   logic [W-1:0]      word_i_w;
   logic [W-1:0]      word_q_w;

   assign idx = paddr_in[ADDR_W-1:2];

   // Each stream owns one field; joining them here keeps a single driver on the port.
   assign tp_out = {word_i_w, word_q_w};

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   // Every access takes one wait state so that read data and the error
   // flag can come straight from flip-flops.
   assign access  = psel_in && penable_in;
   assign wr_take = access && pready_out && pwrite_in;

   always_comb begin
      mapped = (paddr_in[1:0] == 2'b00);
      unique case (idx)
         (ADDR_W-2)'(`TPG_IDX_CUST1_LO),
         (ADDR_W-2)'(`TPG_IDX_CUST1_HI),
         (ADDR_W-2)'(`TPG_IDX_CUST2_LO),
         (ADDR_W-2)'(`TPG_IDX_CUST2_HI),
         (ADDR_W-2)'(`TPG_IDX_CHAN_SEL),
         (ADDR_W-2)'(`TPG_IDX_STRM_SEL),
         (ADDR_W-2)'(`TPG_IDX_COMMON),
         (ADDR_W-2)'(`TPG_IDX_PAT_RST),
         (ADDR_W-2)'(`TPG_IDX_STATUS): ;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (paddr_in[1:0] == 2'b00) begin
         unique case (idx)
            (ADDR_W-2)'(`TPG_IDX_CUST1_LO): rd_d[7:0] = cust1_q[7:0];
            (ADDR_W-2)'(`TPG_IDX_CUST1_HI): rd_d[7:0] = cust1_q[15:8];
            (ADDR_W-2)'(`TPG_IDX_CUST2_LO): rd_d[7:0] = cust2_q[7:0];
            (ADDR_W-2)'(`TPG_IDX_CUST2_HI): rd_d[7:0] = cust2_q[15:8];
            (ADDR_W-2)'(`TPG_IDX_CHAN_SEL): rd_d[3:0] = chan_sel_q;
            (ADDR_W-2)'(`TPG_IDX_STRM_SEL): rd_d[7:0] = strm_sel_q;
            (ADDR_W-2)'(`TPG_IDX_COMMON):   rd_d[`TPG_COMMON_BIT] = common_q;
            (ADDR_W-2)'(`TPG_IDX_PAT_RST): begin
               rd_d[`TPG_RST_EN_BIT]  = rst_en_q;
               rd_d[`TPG_RST_REQ_BIT] = rst_req_q;
            end
            (ADDR_W-2)'(`TPG_IDX_STATUS): begin
               rd_d[0] = pat_clear;
               rd_d[1] = phase_w;
            end
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= access && !pready_out;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= access && !pready_out && !mapped;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (access && !pready_out) begin
         prdata_out <= pwrite_in ? 32'h0000_0000 : rd_d;
      end
   end

   // ------------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cust1_q <= {`TPG_RESET_BYTE, `TPG_RESET_BYTE};
         cust2_q <= {`TPG_RESET_BYTE, `TPG_RESET_BYTE};
      end else if (wr_take && paddr_in[1:0] == 2'b00) begin
         if (idx == (ADDR_W-2)'(`TPG_IDX_CUST1_LO)) cust1_q[7:0]  <= pwdata_in[7:0];
         if (idx == (ADDR_W-2)'(`TPG_IDX_CUST1_HI)) cust1_q[15:8] <= pwdata_in[7:0];
         if (idx == (ADDR_W-2)'(`TPG_IDX_CUST2_LO)) cust2_q[7:0]  <= pwdata_in[7:0];
         if (idx == (ADDR_W-2)'(`TPG_IDX_CUST2_HI)) cust2_q[15:8] <= pwdata_in[7:0];
      end
   end

   // Reserved bits are dropped on write so a careless write cannot
   // leave stray state behind.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         chan_sel_q <= `TPG_RESET_SEL;
         strm_sel_q <= `TPG_RESET_BYTE;
         common_q   <= 1'b0;
      end else if (wr_take && paddr_in[1:0] == 2'b00) begin
         if (idx == (ADDR_W-2)'(`TPG_IDX_CHAN_SEL)) chan_sel_q <= pwdata_in[3:0];
         if (idx == (ADDR_W-2)'(`TPG_IDX_STRM_SEL)) strm_sel_q <= pwdata_in[7:0];
         if (idx == (ADDR_W-2)'(`TPG_IDX_COMMON)) begin
            common_q <= pwdata_in[`TPG_COMMON_BIT];
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_en_q  <= 1'b0;
         rst_req_q <= 1'b0;
      end else if (wr_take && paddr_in[1:0] == 2'b00 &&
                   idx == (ADDR_W-2)'(`TPG_IDX_PAT_RST)) begin
         rst_en_q  <= pwdata_in[`TPG_RST_EN_BIT];
         rst_req_q <= pwdata_in[`TPG_RST_REQ_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Pattern selection and generators
   // ------------------------------------------------------------------
   // The request holds the generators at their start for as long as it
   // stays high; software must drop it again to restart them.
   assign pat_clear = rst_en_q && rst_req_q;

   always_comb begin
      if (common_q) begin
         eff_q_sel = strm_sel_q[`TPG_Q_SEL_MSB:`TPG_Q_SEL_LSB];
         eff_i_sel = strm_sel_q[`TPG_I_SEL_MSB:`TPG_I_SEL_LSB];
      end else begin
         eff_q_sel = chan_sel_q;
         eff_i_sel = chan_sel_q;
      end
   end

   tpg_phase #(
      .W (W)
   ) u_phase (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .clear_in  (pat_clear),
      .ramp_out  (ramp_w),
      .phase_out (phase_w)
   );

   tpg_stream #(
      .W (W)
   ) u_stream_i (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .sel_in    (eff_i_sel),
      .data_in   (adc_in.i),
      .ramp_in   (ramp_w),
      .phase_in  (phase_w),
      .cust1_in  (cust1_q),
      .cust2_in  (cust2_q),
      .word_out  (word_i_w)
   );

   tpg_stream #(
      .W (W)
   ) u_stream_q (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .sel_in    (eff_q_sel),
      .data_in   (adc_in.q),
      .ramp_in   (ramp_w),
      .phase_in  (phase_w),
      .cust1_in  (cust1_q),
      .cust2_in  (cust2_q),
      .word_out  (word_q_w)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   q_nibble_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (common_q && strm_sel_q[7:4] == 4'h1 && strm_sel_q[3:0] == 4'hE)
      |=> (tp_out.q == '0) && (tp_out.i == $past(adc_in.i)))
      else $error("Q nibble did not steer Q stream");

   i_nibble_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (common_q && strm_sel_q[3:0] == 4'h9 && strm_sel_q[7:4] == 4'h6)
      |=> (tp_out.i == '1) && (tp_out.q == $past(cust1_q)))
      else $error("I nibble did not steer I stream");

   pass_data_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (resetn_in && !common_q && chan_sel_q == 4'h0) |=> tp_out == $past(adc_in))
      else $error("normal mode altered data");

   toggle_word_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!common_q && chan_sel_q == 4'h3 && !phase_w && !pat_clear)
      ##1 (!common_q && chan_sel_q == 4'h3)
      |-> tp_out.i == 16'hAAAA ##1 tp_out.i == 16'h5555)
      else $error("toggle pattern wrong");

   ramp_out_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!common_q && chan_sel_q == 4'h4 && !pat_clear)
      ##1 (chan_sel_q == 4'h4 && !common_q)
      |=> tp_out.q == 16'($past(tp_out.q) + 16'h0001))
      else $error("ramp output did not step");

   chan_wide_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!common_q && chan_sel_q == 4'h2)
      |=> tp_out.i == '1 && tp_out.q == '1)
      else $error("channel select not applied to all streams");

   per_stream_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (common_q && strm_sel_q == 8'hF0 && chan_sel_q == 4'h2)
      |=> tp_out == $past(adc_in))
      else $error("per-stream select ignored");

   rst_gate_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (rst_req_q && !rst_en_q) |=> ramp_w == 16'($past(ramp_w) + 16'h0001))
      else $error("ungated reset request acted");

   cust_write_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (wr_take && paddr_in == ADDR_W'({`TPG_IDX_CUST2_HI, 2'b00}))
      |=> cust2_q[15:8] == $past(pwdata_in[7:0]))
      else $error("custom word write lost");

   reserved_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (access && !pready_out && !pwrite_in &&
       paddr_in == ADDR_W'({`TPG_IDX_PAT_RST, 2'b00}))
      |=> prdata_out[31:2] == 30'h0000_0000)
      else $error("reserved bits read non-zero");

   apb_wait_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (access && !pready_out) |=> pready_out ##1 !pready_out)
      else $error("APB ready not single cycle");

   bus_error_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (access && !pready_out && !mapped) |=> pslverr_out && pready_out)
      else $error("unmapped access not refused");

   rst_hold_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (pat_clear && !common_q && chan_sel_q == 4'h4) ##1
      (pat_clear && !common_q && chan_sel_q == 4'h4) |=> tp_out.i == '0)
      else $error("pattern clear did not hold ramp");

   chan_code_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!common_q && chan_sel_q == 4'h8) |=> tp_out.q == 16'hAAAA)
      else $error("channel code table not applied");

   q_sync_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (common_q && strm_sel_q[7:4] == 4'h9) |=> tp_out.q == 16'hFFFF)
      else $error("Q select not applied");

   double_word_a: assert property (
      @(posedge clock_in) disable iff (!resetn_in)
      (!common_q && chan_sel_q == 4'h7 && !phase_w) |=> tp_out.i == $past(cust1_q))
      else $error("double pattern did not start with word one");

endmodule

`default_nettype wire

//--- tpg_link_model.sv
// Converter-side sample source and the link-side view of what was sent.
`timescale 1ns/1ps
`default_nettype none

module tpg_link_model (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   output tpg_pkg::tpg_iq_t adc_out,
   output tpg_pkg::tpg_iq_t sent_out
);
   import tpg_pkg::*;

   // -------------------------------------------------------------
   // Sample source
   // -------------------------------------------------------------
   // Both words move every cycle by unrelated odd steps.
   // A stuck, swapped or stale stream therefore cannot match by chance.
   // The sent copy holds the word the generator sampled at the last edge.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         adc_out  <= {16'h1357, 16'h8642};
         sent_out <= '0;
      end else begin
         sent_out  <= adc_out;
         adc_out.i <= adc_out.i + 16'h0B3D;
         adc_out.q <= adc_out.q - 16'h0751;
      end
   end
endmodule

`default_nettype wire

//--- tb_top.sv
// Self-checking testbench of the test-pattern generator.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_regs.svh"

`define CHK(nm, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
   end \
end

module tb_top;
   import tpg_pkg::*;

   localparam logic [15:0] C1 = 16'hC3A5;
   localparam logic [15:0] C2 = 16'h1E69;

   logic        clock_in;
   logic        resetn_in;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   tpg_iq_t     adc;
   tpg_iq_t     tp;
   tpg_iq_t     sent;
   int          err_total;
   int          checked;

   tpg_top dut_u (
      .clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .adc_in(adc), .tp_out(tp)
   );

   tpg_link_model lm_u (
      .clock_in(clock_in), .resetn_in(resetn_in), .adc_out(adc), .sent_out(sent)
   );

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   // -------------------------------------------------------------
   // Bus and sampling helpers
   // -------------------------------------------------------------
   task automatic tick();
      @(posedge clock_in);
      #1;
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clock_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      `CHK("bus answer", 1'b1, pready)
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
      logic [7:0] r;
      logic       e;
      apb(1'b0, idx, 8'h00, r, e);
      `CHK(nm, exp, r)
   endtask

   task automatic grab(output tpg_iq_t s0, s1, a0, a1);
      tick();
      s0 = tp;
      a0 = sent;
      tick();
      s1 = tp;
      a1 = sent;
   endtask

   task automatic chk_pat(input string nm, input logic [3:0] c,
                          input logic [15:0] w0, w1, a1);
      case (c)
         4'h1: `CHK(nm, 16'h0000, w1)
         4'h2: `CHK(nm, 16'hFFFF, w1)
         4'h3: `CHK(nm, {~w0, 1'b1}, {w1, w0 == 16'hAAAA || w0 == 16'h5555})
         4'h4: `CHK(nm, w0 + 16'h0001, w1)
         4'h6: `CHK(nm, C1, w1)
         4'h7: `CHK(nm, {w0 == C1 ? C2 : C1, 1'b1}, {w1, w0 == C1 || w0 == C2})
         4'h8: `CHK(nm, 16'hAAAA, w1)
         4'h9: `CHK(nm, 16'hFFFF, w1)
         default: `CHK(nm, a1, w1)
      endcase
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] r;
      logic       e;
      for (int k = 8'h33; k <= 8'h3A; k++) rd_chk(8'(k), 8'h00, "reset value");
      wr(`TPG_IDX_CUST1_LO, C1[7:0]);
      wr(`TPG_IDX_CUST1_HI, C1[15:8]);
      wr(`TPG_IDX_CUST2_LO, C2[7:0]);
      wr(`TPG_IDX_CUST2_HI, C2[15:8]);
      rd_chk(`TPG_IDX_CUST1_LO, C1[7:0], "cust1 lo");
      rd_chk(`TPG_IDX_CUST1_HI, C1[15:8], "cust1 hi");
      rd_chk(`TPG_IDX_CUST2_LO, C2[7:0], "cust2 lo");
      rd_chk(`TPG_IDX_CUST2_HI, C2[15:8], "cust2 hi");
      wr(`TPG_IDX_CHAN_SEL, 8'hF7);
      rd_chk(`TPG_IDX_CHAN_SEL, 8'h07, "chan sel unused");
      wr(`TPG_IDX_COMMON, 8'hFE);
      rd_chk(`TPG_IDX_COMMON, 8'h00, "common unused");
      wr(`TPG_IDX_PAT_RST, 8'hFC);
      rd_chk(`TPG_IDX_PAT_RST, 8'h00, "clear unused");
      apb(1'b0, 8'h50, 8'h00, r, e);
      `CHK("unmapped error", 1'b1, e)
      $display("test regs done");
   endtask

   task automatic t_common();
      tpg_iq_t s0, s1, a0, a1;
      wr(`TPG_IDX_COMMON, 8'h00);
      wr(`TPG_IDX_STRM_SEL, 8'h21);
      for (int c = 0; c < 16; c++) begin
         wr(`TPG_IDX_CHAN_SEL, 8'(c));
         grab(s0, s1, a0, a1);
         chk_pat("chan i", 4'(c), s0.i, s1.i, a1.i);
         chk_pat("chan q", 4'(c), s0.q, s1.q, a1.q);
      end
      $display("test common done");
   endtask

   task automatic t_stream();
      tpg_iq_t s0, s1, a0, a1;
      wr(`TPG_IDX_CHAN_SEL, 8'h02);
      wr(`TPG_IDX_COMMON, 8'h01);
      for (int c = 0; c < 16; c++) begin
         wr(`TPG_IDX_STRM_SEL, {4'(c), 4'(15 - c)});
         grab(s0, s1, a0, a1);
         chk_pat("stream i", 4'(15 - c), s0.i, s1.i, a1.i);
         chk_pat("stream q", 4'(c), s0.q, s1.q, a1.q);
      end
      $display("test stream done");
   endtask

   task automatic t_clear();
      tpg_iq_t s0, s1, a0, a1;
      int      n;
      wr(`TPG_IDX_COMMON, 8'h00);
      wr(`TPG_IDX_CHAN_SEL, 8'h04);
      wr(`TPG_IDX_PAT_RST, 8'h02);
      grab(s0, s1, a0, a1);
      `CHK("clear gated", s0.i + 16'h0001, s1.i)
      wr(`TPG_IDX_PAT_RST, 8'h03);
      tick();
      grab(s0, s1, a0, a1);
      `CHK("ramp held", {16'h0000, 16'h0000}, {s0.i, s1.i})
      rd_chk(`TPG_IDX_STATUS, 8'h01, "clear status");
      wr(`TPG_IDX_CHAN_SEL, 8'h03);
      tick();
      grab(s0, s1, a0, a1);
      `CHK("toggle held", {16'hAAAA, 16'hAAAA}, {s0.q, s1.q})
      wr(`TPG_IDX_CHAN_SEL, 8'h04);
      wr(`TPG_IDX_PAT_RST, 8'h01);
      // The full count from zero takes 65536 cycles; the wrap is the boundary case.
      n = 0;
      do begin
         tick();
         n++;
      end while (tp.i !== 16'hFFFF && n < 66000);
      `CHK("ramp top reached", 32'd65536, n)
      tick();
      `CHK("ramp wrap", 16'h0000, tp.i)
      $display("test clear done");
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #1600000;
      err_total++;
      $display("mismatch watchdog expected done seen hang");
      end_sim();
   end

   initial begin
      resetn_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      err_total = 0;
      checked = 0;
      repeat (16) @(posedge clock_in);
      resetn_in <= 1'b1;
      tick();
      tick();
      `CHK("reset pass", sent, tp)
      t_regs();
      t_common();
      t_stream();
      t_clear();
      end_sim();
   end
endmodule

`default_nettype wire
